// file: src/capacitive_sense_control.sv
// Purpose: control logic of the capacitive sense unit
// Assumes: comparator output synchronous to clk_i, timer sources sampled on clk_i
// Notes:   sense clock and timer clocks are level paths passed as strobes
//
// The placing of the registers and strobed register access were decided locally.
`include "cap_sense_map.svh"
`default_nettype none
module capacitive_sense_control (
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire logic [3:0]                 addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [7:0]                 rdata_o,
    input  wire logic                       comparator_i,
    input  wire logic                       timer_a_pin_clock_i,
    input  wire logic                       timer_b_other_clock_i,
    input  wire logic                       timer_b_gate_i,
    output cap_sense_pkg::analog_ctl_t      analog_o,
    output cap_sense_pkg::timer_ctl_t       timer_o,
    output cap_sense_pkg::power_mode_t      power_mode_o,
    output logic                            noise_activity_o
);
    logic [1:0]                  rst_sync;
    logic                        rst_n;
    cap_sense_pkg::state_t       st;
    cap_sense_pkg::state_t       next_st;
    cap_sense_pkg::power_mode_t  mode;
    logic                        enabled;
    logic                        sense_clock;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // eight mode decode from reference bit and range code
    function automatic cap_sense_pkg::power_mode_t decode_mode(input logic [7:0] c0);
        logic [1:0] rng;
        rng = c0[`C0_RANGE_LSB +: 2];
        if (c0[`C0_REFMODE_BIT]) begin
            unique case (rng)
                2'h0: decode_mode = cap_sense_pkg::PM_NOISE;
                2'h1: decode_mode = cap_sense_pkg::PM_V_LOW;
                2'h2: decode_mode = cap_sense_pkg::PM_V_MED;
                2'h3: decode_mode = cap_sense_pkg::PM_V_HIGH;
            endcase
        end else begin
            unique case (rng)
                2'h0: decode_mode = cap_sense_pkg::PM_OFF;
                2'h1: decode_mode = cap_sense_pkg::PM_F_LOW;
                2'h2: decode_mode = cap_sense_pkg::PM_F_MED;
                2'h3: decode_mode = cap_sense_pkg::PM_F_HIGH;
            endcase
        end
    endfunction

    assign mode    = decode_mode(st.sense_control_0);
    assign enabled = st.sense_control_0[`C0_ENABLE_BIT];

    // next state: register writes, direction tracking, read data
    always_comb begin
        next_st = st;
        if (wr_i) begin
            unique case (addr_i)
                `SENSE_CONTROL_0_ADDR: next_st.sense_control_0 = wdata_i & `WR_MASK_C0;
                `SENSE_CONTROL_1_ADDR: next_st.sense_control_1 = wdata_i & `WR_MASK_C1;
                `TIMER_A_OPTION_ADDR:  next_st.timer_a_option  = wdata_i & `WR_MASK_TA;
                `TIMER_B_CONTROL_ADDR: next_st.timer_b_control = wdata_i & `WR_MASK_TB;
                default: ;
            endcase
        end
        if (enabled && mode != cap_sense_pkg::PM_OFF) begin
            next_st.dir = comparator_i;
        end
        next_st.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `SENSE_CONTROL_0_ADDR: next_st.rdata = {st.sense_control_0[7:2], st.dir,
                                                        st.sense_control_0[0]};
                `SENSE_CONTROL_1_ADDR: next_st.rdata = st.sense_control_1;
                `TIMER_A_OPTION_ADDR:  next_st.rdata = st.timer_a_option;
                `TIMER_B_CONTROL_ADDR: next_st.rdata = st.timer_b_control;
                `SENSE_STATUS_ADDR:    next_st.rdata = {5'h00, mode};
                default:               next_st.rdata = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{`REG_RESET, `REG_RESET, `REG_RESET, `REG_RESET, 8'h00, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;

    // analog mux and oscillator current controls
    always_comb begin
        analog_o = '0;
        if (enabled) begin
            analog_o.channel_enable[st.sense_control_1[1:0]] = 1'b1;
        end
        analog_o.variable_reference = st.sense_control_0[`C0_REFMODE_BIT];
        analog_o.comparator_enable  = enabled && mode != cap_sense_pkg::PM_OFF;
        analog_o.source_enable      = enabled && mode != cap_sense_pkg::PM_OFF
                                      && mode != cap_sense_pkg::PM_NOISE;
        analog_o.sink_enable        = analog_o.source_enable;
    end

    assign power_mode_o     = mode;
    assign sense_clock      = st.dir;
    assign noise_activity_o = (mode == cap_sense_pkg::PM_NOISE) && enabled && st.dir;

    // timer clock routing and second timer enable
    always_comb begin
        timer_o.timer_a_clock = st.sense_control_0[`C0_TA_EXT_BIT] ? sense_clock
                                                                   : timer_a_pin_clock_i;
        timer_o.timer_b_clock = (st.timer_b_control[`TB_CLKSRC_LSB +: 2] == `TB_SRC_SENSE)
                                ? sense_clock : timer_b_other_clock_i;
        timer_o.timer_b_count_enable = st.timer_b_control[`TB_ON_BIT] &&
                                       (!st.timer_b_control[`TB_GATE_EN_BIT]
                                        || timer_b_gate_i);
    end

    // checks: range code seen by the decode checks
    logic [1:0] range_code;
    assign range_code = st.sense_control_0[`C0_RANGE_LSB +: 2];

    // disabled unit drives no channel
    a_disabled_no_channel: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !enabled |-> analog_o.channel_enable == 4'h0)
        else $error("channel on while disabled");

    // enabled unit routes the selected code
    a_channel_onehot: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        enabled |-> analog_o.channel_enable == (4'h1 << st.sense_control_1[1:0]))
        else $error("wrong channel");

    // never more than one pad on the oscillator
    a_one_channel: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        $onehot0(analog_o.channel_enable))
        else $error("several channels");

    // direction bit follows the comparator while running
    a_dir_tracks: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (enabled && mode != cap_sense_pkg::PM_OFF) |=> st.dir == $past(comparator_i))
        else $error("direction not tracking");

    // direction bit frozen while oscillator off
    a_off_dir_static: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (mode == cap_sense_pkg::PM_OFF && $past(mode) == cap_sense_pkg::PM_OFF) |-> $stable(st.dir))
        else $error("direction moved while off");

    // noise mode drives no pin current
    a_noise_no_current: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        mode == cap_sense_pkg::PM_NOISE |-> !analog_o.source_enable && !analog_o.sink_enable)
        else $error("current in noise mode");

    // noise mode keeps the comparator alive
    a_noise_comp_on: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (mode == cap_sense_pkg::PM_NOISE && enabled) |-> analog_o.comparator_enable)
        else $error("comparator off in noise mode");

    // reference select matches the variable modes
    a_refmode_follow: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        analog_o.variable_reference == (mode inside {cap_sense_pkg::PM_NOISE,
        cap_sense_pkg::PM_V_LOW, cap_sense_pkg::PM_V_MED, cap_sense_pkg::PM_V_HIGH}))
        else $error("reference mismatch");

    // variable reference with code 00 is noise detection
    a_mode_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (wr_i && addr_i == `SENSE_CONTROL_0_ADDR && wdata_i[7:2] == 6'h30) |=> mode == cap_sense_pkg::PM_NOISE)
        else $error("mode decode wrong");

    // fixed reference with code 00 is off
    a_fixed_zero_off: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (wr_i && addr_i == `SENSE_CONTROL_0_ADDR && wdata_i[7:2] == 6'h20) |=> mode == cap_sense_pkg::PM_OFF)
        else $error("off decode wrong");

    // code 01 is low current in both ranges
    a_range_low: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        range_code == 2'h1 |-> mode inside {cap_sense_pkg::PM_F_LOW, cap_sense_pkg::PM_V_LOW})
        else $error("low range decode wrong");

    // code 10 is medium current in both ranges
    a_range_med: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        range_code == 2'h2 |-> mode inside {cap_sense_pkg::PM_F_MED, cap_sense_pkg::PM_V_MED})
        else $error("medium range decode wrong");

    // code 11 is high current in both ranges
    a_range_high: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        range_code == 2'h3 |-> mode inside {cap_sense_pkg::PM_F_HIGH, cap_sense_pkg::PM_V_HIGH})
        else $error("high range decode wrong");

    // disabled unit leaves the oscillator idle
    a_disabled_no_current: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !enabled |-> !analog_o.source_enable && !analog_o.comparator_enable)
        else $error("oscillator on while disabled");

    // off mode stops comparator and current
    a_off_no_comparator: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        mode == cap_sense_pkg::PM_OFF |-> !analog_o.comparator_enable && !analog_o.sink_enable)
        else $error("oscillator on while off");

    // current ranges source and sink
    a_range_current: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (enabled && range_code != 2'h0) |-> analog_o.source_enable && analog_o.sink_enable)
        else $error("current missing in range");

    // activity only in enabled noise mode
    a_activity_noise: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        noise_activity_o |-> enabled && mode == cap_sense_pkg::PM_NOISE)
        else $error("activity outside noise mode");

    // activity follows comparator toggles in noise mode
    a_activity_follows: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (enabled && mode == cap_sense_pkg::PM_NOISE && !wr_i)
        |=> noise_activity_o == $past(comparator_i))
        else $error("activity not following comparator");

    // second timer clock from the sense oscillator on code 11
    a_tb_sense_clock: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.timer_b_control[7:6] == `TB_SRC_SENSE |-> timer_o.timer_b_clock == st.dir)
        else $error("second timer not on sense clock");

    // second timer keeps its other clock otherwise
    a_tb_other_clock: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.timer_b_control[7:6] != `TB_SRC_SENSE
        |-> timer_o.timer_b_clock == timer_b_other_clock_i)
        else $error("second timer clock wrong");

    // first timer clock from the sense oscillator
    a_ta_sense_clock: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.sense_control_0[0] |-> timer_o.timer_a_clock == st.dir)
        else $error("first timer not on sense clock");

    // first timer keeps its pin clock otherwise
    a_ta_pin_clock: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !st.sense_control_0[`C0_TA_EXT_BIT] |-> timer_o.timer_a_clock == timer_a_pin_clock_i)
        else $error("first timer clock wrong");

    // second timer off while its on bit is clear
    a_tb_off: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !st.timer_b_control[0] |-> !timer_o.timer_b_count_enable)
        else $error("second timer runs while off");

    // second timer free running without gate
    a_tb_free: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.timer_b_control[1:0] == 2'h1 |-> timer_o.timer_b_count_enable)
        else $error("second timer not free running");

    // second timer counts only while the gate allows
    a_tb_gated: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (st.timer_b_control[1:0] == 2'h3) |-> timer_o.timer_b_count_enable == timer_b_gate_i)
        else $error("gate ignored");

    // readback carries the direction bit
    a_dir_readback: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        $past(rd_i && addr_i == `SENSE_CONTROL_0_ADDR) |-> rdata_o[`C0_DIR_BIT] == $past(st.dir))
        else $error("direction readback wrong");

    // status readback carries the power mode
    a_status_read: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        $past(rd_i && addr_i == `SENSE_STATUS_ADDR) |-> rdata_o == {5'h00, $past(mode)})
        else $error("status readback wrong");

    // reserved and read-only bits never stored
    a_c0_reserved: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.sense_control_0[5:4] == 2'h0 && !st.sense_control_0[`C0_DIR_BIT])
        else $error("reserved bit stored");

    // only the channel field is stored
    a_c1_reserved: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.sense_control_1[7:2] == 6'h00)
        else $error("reserved channel bit stored");

    // enable bit taken from the write
    a_enable_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (wr_i && addr_i == `SENSE_CONTROL_0_ADDR) |=> enabled == $past(wdata_i[`C0_ENABLE_BIT]))
        else $error("enable not written");

    // noise activity seen
    c_noise_mode: cover property (
        @(posedge clk_i) disable iff (!rst_n) noise_activity_o);

    // last channel selected
    c_channel_3: cover property (
        @(posedge clk_i) disable iff (!rst_n) analog_o.channel_enable[3]);

    // gated count window open
    c_tb_gated_count: cover property (
        @(posedge clk_i) disable iff (!rst_n) timer_o.timer_b_count_enable && st.timer_b_control[1]);

    // status register read
    c_readback: cover property (
        @(posedge clk_i) disable iff (!rst_n) rd_i && addr_i == `SENSE_STATUS_ADDR);

    // variable high range in use
    c_variable_high: cover property (
        @(posedge clk_i) disable iff (!rst_n) enabled && mode == cap_sense_pkg::PM_V_HIGH);
endmodule
`default_nettype wire

// file: src/cap_sense_map.svh
// Purpose: offsets, field positions and reset values of the sense control block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   included by its bare name
`ifndef CAP_SENSE_MAP_SVH
`define CAP_SENSE_MAP_SVH
`define SENSE_CONTROL_0_ADDR 4'h0
`define SENSE_CONTROL_1_ADDR 4'h1
`define TIMER_A_OPTION_ADDR  4'h2
`define TIMER_B_CONTROL_ADDR 4'h3
`define SENSE_STATUS_ADDR    4'h4
`define C0_ENABLE_BIT        7
`define C0_REFMODE_BIT       6
`define C0_RANGE_LSB         2
`define C0_DIR_BIT           1
`define C0_TA_EXT_BIT        0
`define TA_CLKSRC_BIT        5
`define TB_CLKSRC_LSB        6
`define TB_GATE_EN_BIT       1
`define TB_ON_BIT            0
`define REG_RESET            8'h00
`define TB_SRC_SENSE         2'h3
`define WR_MASK_C0           8'hCD
`define WR_MASK_C1           8'h03
`define WR_MASK_TA           8'h20
`define WR_MASK_TB           8'hC3
`endif

// file: src/cap_sense_pkg.sv
// Purpose: types of the sense control block
// Assumes: nothing
// Notes:   constants live in cap_sense_map.svh
`default_nettype none
package cap_sense_pkg;
    typedef enum logic [2:0] {
        PM_OFF    = 3'b000,
        PM_NOISE  = 3'b001,
        PM_F_LOW  = 3'b010,
        PM_F_MED  = 3'b011,
        PM_F_HIGH = 3'b100,
        PM_V_LOW  = 3'b101,
        PM_V_MED  = 3'b110,
        PM_V_HIGH = 3'b111
    } power_mode_t;
    typedef struct packed {
        logic [7:0] sense_control_0;
        logic [7:0] sense_control_1;
        logic [7:0] timer_a_option;
        logic [7:0] timer_b_control;
        logic [7:0] rdata;
        logic       dir;
    } state_t;
    typedef struct packed {
        logic [3:0] channel_enable;
        logic       source_enable;
        logic       sink_enable;
        logic       comparator_enable;
        logic       variable_reference;
    } analog_ctl_t;
    typedef struct packed {
        logic timer_a_clock;
        logic timer_b_clock;
        logic timer_b_count_enable;
    } timer_ctl_t;
endpackage
`default_nettype wire

// file: tb/touch_pad_model.sv
// Purpose: touch pad and oscillator front end facing the sense control
// Assumes: comparator level follows the level the bench commands
// Notes:   an unselected pad floats, shown as a level toggling each cycle
`default_nettype none
module touch_pad_model (
    input  wire logic                       clk_i,
    input  wire cap_sense_pkg::analog_ctl_t analog_i,
    input  wire logic                       level_i,
    output var  logic                       comparator_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_q = 1'b0;
    // floating pad never holds its last value
    always_ff @(posedge clk_i) float_q <= ~float_q;
    // pad answers only on a selected analog input
    assign comparator_o = (|analog_i.channel_enable) ? level_i : float_q;
endmodule
`default_nettype wire

// file: tb/capacitive_sense_control_bench.sv
// Purpose: self-checking bench of the sense control block
// Assumes: one-cycle strobes, read data in the cycle after the read
// Notes:   sense clock path checked by both timer clocks following the pad level
`include "cap_sense_map.svh"
`default_nettype none
module capacitive_sense_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk_i = 1'b0;
    logic                       nrst_i = 1'b0;
    logic [3:0]                 addr_i = 4'h0;
    logic [7:0]                 wdata_i = 8'h00;
    logic                       wr_i = 1'b0;
    logic                       rd_i = 1'b0;
    logic                       level = 1'b0;
    logic                       ta_pin = 1'b0;
    logic                       tb_other = 1'b0;
    logic                       gate = 1'b0;
    logic [7:0]                 rdata_o;
    logic                       comparator;
    logic                       noise_activity_o;
    cap_sense_pkg::analog_ctl_t analog_o;
    cap_sense_pkg::timer_ctl_t  timer_o;
    cap_sense_pkg::power_mode_t power_mode_o;
    int                         miscompares = 0;
    int                         cmp_count = 0;
    logic [7:0]                 e;
    int                         rises = 0;
    logic                       prev_clk = 1'b0;
    capacitive_sense_control u_capacitive_sense_control (.clk_i(clk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .comparator_i(comparator), .timer_a_pin_clock_i(ta_pin),
        .timer_b_other_clock_i(tb_other), .timer_b_gate_i(gate), .analog_o(analog_o),
        .timer_o(timer_o), .power_mode_o(power_mode_o), .noise_activity_o(noise_activity_o));
    touch_pad_model u_touch_pad_model (.clk_i(clk_i), .analog_i(analog_o), .level_i(level),
        .comparator_o(comparator));
    // port value compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one-cycle register write, outputs settled on return
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // one-cycle read, data looked at in the following cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        cmp_count++;
        if (rdata_o !== exp) begin
            miscompares++;
            $display("Error at %0t: read %h got %h expected %h", $time, a, rdata_o, exp);
        end
    endtask
    // pad level change, given time to be sampled
    task automatic set_level(input logic v);
        @(posedge clk_i);
        level <= v;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // 100 MHz clock
    initial forever #5 clk_i = ~clk_i;
    // hang guard
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int a = 0; a < 5; a++) rd(a[3:0], `REG_RESET);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        wr(`SENSE_CONTROL_1_ADDR, 8'hFF);
        rd(`SENSE_CONTROL_1_ADDR, `WR_MASK_C1);
        wr(`TIMER_A_OPTION_ADDR, 8'hFF);
        rd(`TIMER_A_OPTION_ADDR, `WR_MASK_TA);
        wr(`TIMER_B_CONTROL_ADDR, 8'hFF);
        rd(`TIMER_B_CONTROL_ADDR, `WR_MASK_TB);
        wr(`SENSE_CONTROL_0_ADDR, 8'h3F);
        rd(`SENSE_CONTROL_0_ADDR, 8'h0D);
        chk({4'h0, analog_o.channel_enable}, 8'h00, "mux off");
        $display("test registers done");
        // each channel code while enabled
        for (int c = 0; c < 4; c++) begin
            wr(`SENSE_CONTROL_1_ADDR, 8'(c));
            wr(`SENSE_CONTROL_0_ADDR, 8'h84);
            chk({4'h0, analog_o.channel_enable}, 8'h01 << c, "mux");
        end
        $display("test channels done");
        // every reference and range combination
        for (int m = 0; m < 8; m++) begin
            wr(`SENSE_CONTROL_0_ADDR, {1'b1, m[2], 2'b00, m[1:0], 2'b00});
            if (m[1:0] == 2'h0) e = m[2] ? 8'h01 : 8'h00;
            else e = 8'((m[2] ? cap_sense_pkg::PM_V_LOW : cap_sense_pkg::PM_F_LOW) + m[1:0] - 1);
            chk({5'h0, power_mode_o}, e, "mode");
            chk({7'h0, analog_o.variable_reference}, {7'h0, m[2]}, "reference");
            rd(`SENSE_STATUS_ADDR, e);
            if (m == 4) begin
                chk({5'h0, analog_o.source_enable, analog_o.sink_enable,
                     analog_o.comparator_enable}, 8'h01, "noise");
                set_level(1'b1);
                chk({7'h0, noise_activity_o}, 8'h01, "activity");
                set_level(1'b0);
                chk({7'h0, noise_activity_o}, 8'h00, "activity");
            end
        end
        $display("test modes done");
        // direction follows comparator, frozen while off
        wr(`SENSE_CONTROL_0_ADDR, 8'h84);
        set_level(1'b1);
        rd(`SENSE_CONTROL_0_ADDR, 8'h86);
        set_level(1'b0);
        rd(`SENSE_CONTROL_0_ADDR, 8'h84);
        wr(`SENSE_CONTROL_0_ADDR, 8'h80);
        set_level(1'b1);
        rd(`SENSE_CONTROL_0_ADDR, 8'h80);
        $display("test direction done");
        // timer clock routing
        wr(`SENSE_CONTROL_0_ADDR, 8'h84);
        wr(`TIMER_B_CONTROL_ADDR, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            ta_pin <= i[0];
            tb_other <= ~i[0];
            @(posedge clk_i);
            #1;
            chk({6'h0, timer_o.timer_a_clock, timer_o.timer_b_clock},
                {6'h0, i[0], ~i[0]}, "pin clocks");
        end
        wr(`SENSE_CONTROL_0_ADDR, 8'h85);
        wr(`TIMER_A_OPTION_ADDR, 8'h00);
        wr(`TIMER_B_CONTROL_ADDR, 8'hC0);
        set_level(1'b1);
        chk({6'h0, timer_o.timer_a_clock, timer_o.timer_b_clock}, 8'h03, "sense clock");
        set_level(1'b0);
        chk({6'h0, timer_o.timer_a_clock, timer_o.timer_b_clock}, 8'h00, "sense clock");
        // on, gate enable and gate level table
        for (int i = 0; i < 8; i++) begin
            wr(`TIMER_B_CONTROL_ADDR, {6'h00, i[1], i[0]});
            @(posedge clk_i);
            gate <= i[2];
            @(posedge clk_i);
            #1;
            chk({7'h0, timer_o.timer_b_count_enable},
                {7'h0, i[0] & (~i[1] | i[2])}, "count");
        end
        // 16-cycle window from a bench loop gates a 4-cycle pad period: 4 counts
        wr(`TIMER_B_CONTROL_ADDR, 8'hC3);
        set_level(1'b0);
        rises = 0;
        prev_clk = timer_o.timer_b_clock;
        for (int k = 0; k < 24; k++) begin
            @(posedge clk_i);
            level <= k[1];
            gate <= (k < 16);
            #1;
            if (timer_o.timer_b_count_enable && timer_o.timer_b_clock && !prev_clk) rises++;
            prev_clk = timer_o.timer_b_clock;
        end
        chk(8'(rises), 8'h04, "window count");
        $display("test timers done");
        complete_run();
    end
endmodule
`default_nettype wire
